/* File: scs_pkg.sv */
/*
 * Constants for the per-socket command sequencer: register offsets, command
 * codes, protocol settings, socket state codes, event flag positions, reset values.
 * Assumes one shared system clock and reset for all users of the package.
 */
// Operation
// RL1: Once a written command has been taken, the command register returns to zero by itself.
// RL2: The zeroed command register is no sign of completion; state code and event flags tell that.
// RL3: Command 0x01 opens the socket in the protocol currently chosen by the protocol select field.
// RL4: After an open the state code reads 0x13 for TCP, 0x22 for UDP and 0x32 for raw IP.
// RL5: On socket zero only, an open gives 0x42 for raw MAC (0x04) and 0x5F for the DSL session setting (0x05).
// RL6: Command 0x02 makes a TCP server that waits for SYN and is to be issued only with TCP selected.
// RL7: Listen moves the state from the TCP initialized code to the server waiting code.
// RL8: A successful incoming connection while listening gives the connected state and event bit 0.
// RL9: A failed SYN/ACK transfer while listening sets event bit 3 and shuts the socket.
// RL10: A request to a missing port makes the block ask for a TCP RST and leaves the state code alone.
// RL11: Command 0x04, TCP only, starts a client connect with SYN to the destination IP and port.
// RL12: A successful client connection gives the connected state and event bit 0.
// RL13: A connect fails with the address resolution timeout flag when ARP yields no hardware address.
// RL14: A connect fails with the TCP timeout flag, event bit 3, when no SYN/ACK arrives.
// RL15: A connect also fails when the remote side answers the SYN with RST.
// RL16: Each of the three connect failures puts the state code to the shut state.
// RL17: Listen or connect while TCP is not selected changes neither state code nor event flags.
`default_nettype none

package scs_pkg;
    localparam logic [15:0] SCS_OFS_MODE   = 16'h4000;
    localparam logic [15:0] SCS_OFS_CMD    = 16'h4001;
    localparam logic [15:0] SCS_OFS_FLAGS  = 16'h4002;
    localparam logic [15:0] SCS_OFS_STATE  = 16'h4003;

    localparam logic [7:0]  SCS_CMD_OPEN    = 8'h01;
    localparam logic [7:0]  SCS_CMD_LISTEN  = 8'h02;
    localparam logic [7:0]  SCS_CMD_CONNECT = 8'h04;
    localparam logic [7:0]  SCS_CMD_RESET   = 8'h00;

    localparam logic [3:0]  SCS_PROTO_NONE  = 4'h0;
    localparam logic [3:0]  SCS_PROTO_TCP   = 4'h1;
    localparam logic [3:0]  SCS_PROTO_UDP   = 4'h2;
    localparam logic [3:0]  SCS_PROTO_IPRAW = 4'h3;
    localparam logic [3:0]  SCS_PROTO_MAC   = 4'h4;
    localparam logic [3:0]  SCS_PROTO_DSL   = 4'h5;
    localparam int          SCS_PROTO_LSB   = 0;

    localparam logic [7:0]  SCS_ST_SHUT      = 8'h00;
    localparam logic [7:0]  SCS_ST_TCP_INIT  = 8'h13;
    localparam logic [7:0]  SCS_ST_WAITING   = 8'h14;
    localparam logic [7:0]  SCS_ST_CONNECTED = 8'h17;
    localparam logic [7:0]  SCS_ST_DGRAM     = 8'h22;
    localparam logic [7:0]  SCS_ST_RAW_IP    = 8'h32;
    localparam logic [7:0]  SCS_ST_RAW_MAC   = 8'h42;
    localparam logic [7:0]  SCS_ST_DSL       = 8'h5F;

    localparam int          SCS_FLAG_CON     = 0;
    localparam int          SCS_FLAG_TCP_TIMEOUT_FLAG   = 3;
    localparam int          SCS_FLAG_ADDR_RESOLUTION_TIMEOUT   = 4;

    localparam logic [7:0]  SCS_MODE_RST     = 8'h00;
    localparam logic [7:0]  SCS_FLAGS_RST    = 8'h00;
    localparam logic [7:0]  SCS_RDATA_RST    = 8'h00;
endpackage : scs_pkg

`default_nettype wire

/* File: scs_cmd_reg.sv */
/*
 * Socket command register: host writes a code, the sequencer takes it the
 * next cycle and the register drops back to zero by itself.
 * Assumes the write strobe and write data are on the system clock.
 */
`default_nettype none

module scs_cmd_reg
    import scs_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_cmd
);
    logic [7:0] cmd_q;
    logic [7:0] cmd_d;

    // A new write in the take cycle wins, so no command is dropped
    assign cmd_d = i_wr_en ? i_wdata : SCS_CMD_RESET; // see RL1

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cmd_q <= SCS_CMD_RESET;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    assign o_cmd = cmd_q;
endmodule : scs_cmd_reg

`default_nettype wire

/* File: scs_event_flags.sv */
/*
 * Sticky socket event flags, cleared by writing ones.
 * Assumes set and clear vectors are on the system clock.
 */
`default_nettype none

module scs_event_flags
    import scs_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [7:0] i_set,
    input  wire logic [7:0] i_clr,
    output logic      [7:0] o_flags
);
    logic [7:0] flags_q;
    logic [7:0] flags_d;

    // Set beats clear so an event in the clearing cycle survives
    assign flags_d = (flags_q & ~i_clr) | i_set;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            flags_q <= SCS_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign o_flags = flags_q;
endmodule : scs_event_flags

`default_nettype wire

/* File: scs_sequencer.sv */
/*
 * Per-socket command sequencer: mode, command, event flag and state code
 * registers on the device register port, and the open/listen/connect state walk.
 * Assumes the register port and the protocol engine events are all synchronous
 * to i_ref_clk; the engines carry out SYN, RST and ARP traffic themselves.
 */
`default_nettype none

module scs_sequencer
    import scs_pkg::*;
#(
    parameter logic [2:0] SOCKET_ID = 3'h0
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic        i_reg_wr_en,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_rd_en,
    input  wire logic        i_conn_ok,
    input  wire logic        i_synack_fail,
    input  wire logic        i_arp_timeout,
    input  wire logic        i_syn_timeout,
    input  wire logic        i_rst_received,
    input  wire logic        i_syn_no_port,
    output logic      [7:0]  o_reg_rdata,
    output logic      [7:0]  o_state_code,
    output logic      [3:0]  o_protocol_select_field,
    output logic             o_open_req,
    output logic             o_listen_req,
    output logic             o_connect_req,
    output logic             o_send_rst
);
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAITING,
        SEQ_CONNECTING
    } scs_seq_t;

    localparam logic [15:0] SOCK_OFS = {5'h00, SOCKET_ID, 8'h00};
    localparam logic        IS_SOCK0 = (SOCKET_ID == 3'h0);

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
        hit = (addr == ofs + SOCK_OFS);
    endfunction : hit

    // Open result: valid bit then state code
    function automatic logic [8:0] open_code(input logic [3:0] proto, input logic sock0);
        case (proto)
            SCS_PROTO_TCP:   open_code = {1'b1, SCS_ST_TCP_INIT};
            SCS_PROTO_UDP:   open_code = {1'b1, SCS_ST_DGRAM};
            SCS_PROTO_IPRAW: open_code = {1'b1, SCS_ST_RAW_IP};
            SCS_PROTO_MAC:   open_code = {sock0, SCS_ST_RAW_MAC};
            SCS_PROTO_DSL:   open_code = {sock0, SCS_ST_DSL};
            default:         open_code = {1'b0, SCS_ST_SHUT};
        endcase
    endfunction : open_code

    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] state_q;
    logic [7:0] state_d;
    scs_seq_t   seq_q;
    scs_seq_t   seq_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       open_req_q;
    logic       listen_req_q;
    logic       connect_req_q;
    logic       send_rst_q;

    wire        wr_mode  = i_reg_wr_en & hit(i_reg_addr, SCS_OFS_MODE);
    wire        wr_cmd   = i_reg_wr_en & hit(i_reg_addr, SCS_OFS_CMD);
    wire        wr_flags = i_reg_wr_en & hit(i_reg_addr, SCS_OFS_FLAGS);
    wire  [7:0] cmd;
    wire  [7:0] flags;
    wire  [3:0] proto    = mode_q[SCS_PROTO_LSB +: 4];
    wire        is_tcp   = (proto == SCS_PROTO_TCP);
    wire  [8:0] open_res = open_code(proto, IS_SOCK0);

    // Command decode: the taken cycle is the one where cmd is nonzero
    wire        take_open    = (cmd == SCS_CMD_OPEN);                              // see RL3
    wire        take_listen  = (cmd == SCS_CMD_LISTEN) & is_tcp
                               & (state_q == SCS_ST_TCP_INIT);                     // see RL6
    wire        take_connect = (cmd == SCS_CMD_CONNECT) & is_tcp
                               & (state_q == SCS_ST_TCP_INIT);                     // see RL11
    wire        cmd_taken    = (cmd != SCS_CMD_RESET);

    // Engine events except the no-port request only count while no command is being taken
    wire        in_wait = (seq_q == SEQ_WAITING) & ~cmd_taken;
    wire        in_conn = (seq_q == SEQ_CONNECTING) & ~cmd_taken;
    wire        ev_ok   = (in_wait | in_conn) & i_conn_ok;                         // see RL8, RL12
    wire        ev_lfail = in_wait & ~i_conn_ok & i_synack_fail;                   // see RL9
    wire        ev_arp  = in_conn & ~i_conn_ok & i_arp_timeout;                    // see RL13
    wire        ev_tcp_timeout_flag = in_conn & ~i_conn_ok & ~i_arp_timeout & i_syn_timeout;  // see RL14
    wire        ev_rst  = in_conn & ~i_conn_ok & ~i_arp_timeout & ~i_syn_timeout
                          & i_rst_received;                                        // see RL15
    wire        ev_no_port = (seq_q == SEQ_WAITING) & i_syn_no_port;               // see RL10

    wire  [7:0] flag_set = ({7'h00, ev_ok} << SCS_FLAG_CON)
                         | ({7'h00, ev_lfail | ev_tcp_timeout_flag} << SCS_FLAG_TCP_TIMEOUT_FLAG)
                         | ({7'h00, ev_arp} << SCS_FLAG_ADDR_RESOLUTION_TIMEOUT);
    wire  [7:0] flag_clr = wr_flags ? i_reg_wdata : 8'h00;

    scs_cmd_reg u_cmd (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (wr_cmd),
        .i_wdata   (i_reg_wdata),
        .o_cmd     (cmd)
    );

    scs_event_flags u_flags (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_set     (flag_set),
        .i_clr     (flag_clr),
        .o_flags   (flags)
    );

    assign mode_d = wr_mode ? i_reg_wdata : mode_q;

    // Unmapped addresses read as zero
    assign rdata_d = hit(i_reg_addr, SCS_OFS_MODE)  ? mode_q  :
                     hit(i_reg_addr, SCS_OFS_CMD)   ? cmd     :
                     hit(i_reg_addr, SCS_OFS_FLAGS) ? flags   :
                     hit(i_reg_addr, SCS_OFS_STATE) ? state_q : 8'h00;

    always_comb begin
        state_d = state_q;
        seq_d   = seq_q;
        if (take_open) begin
            // Unknown or closed protocol leaves the state alone
            state_d = open_res[8] ? open_res[7:0] : state_q;               // see RL4, RL5
            seq_d   = SEQ_IDLE;
        end else if (take_listen) begin
            state_d = SCS_ST_WAITING;                                      // see RL7
            seq_d   = SEQ_WAITING;
        end else if (take_connect) begin
            seq_d   = SEQ_CONNECTING;                                      // see RL2, RL11
        end else if (ev_ok) begin
            state_d = SCS_ST_CONNECTED;                                    // see RL8, RL12
            seq_d   = SEQ_IDLE;
        end else if (ev_lfail | ev_arp | ev_tcp_timeout_flag | ev_rst) begin
            state_d = SCS_ST_SHUT;                                         // see RL9, RL16
            seq_d   = SEQ_IDLE;
        end else begin
            case (seq_q)
                SEQ_IDLE:       seq_d = SEQ_IDLE;
                SEQ_WAITING:    seq_d = SEQ_WAITING;
                SEQ_CONNECTING: seq_d = SEQ_CONNECTING;
                default:        seq_d = SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_q        <= SCS_MODE_RST;
            state_q       <= SCS_ST_SHUT;
            seq_q         <= SEQ_IDLE;
            rdata_q       <= SCS_RDATA_RST;
            open_req_q    <= 1'b0;
            listen_req_q  <= 1'b0;
            connect_req_q <= 1'b0;
            send_rst_q    <= 1'b0;
        end else begin
            mode_q        <= mode_d;
            state_q       <= state_d;
            seq_q         <= seq_d;
            rdata_q       <= i_reg_rd_en ? rdata_d : rdata_q;
            open_req_q    <= take_open & open_res[8];
            listen_req_q  <= take_listen;
            connect_req_q <= take_connect;
            send_rst_q    <= ev_no_port;
        end
    end

    assign o_reg_rdata             = rdata_q;
    assign o_state_code            = state_q;
    assign o_protocol_select_field = mode_q[SCS_PROTO_LSB +: 4];
    assign o_open_req              = open_req_q;
    assign o_listen_req            = listen_req_q;
    assign o_connect_req           = connect_req_q;
    assign o_send_rst              = send_rst_q;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_connect_issue;
        cmd == SCS_CMD_CONNECT && is_tcp && state_q == SCS_ST_TCP_INIT;
    endsequence
    sequence s_connect_arp_fail;
        ##[1:20] (seq_q == SEQ_CONNECTING && !cmd_taken && !i_conn_ok && i_arp_timeout);
    endsequence

    property p_cmd_clear;
        cmd_taken && !wr_cmd |=> cmd == SCS_CMD_RESET;
    endproperty
    a_cmd_clear: assert property (p_cmd_clear) else $error("command not cleared"); // see RL1

    property p_open_tcp;
        cmd == SCS_CMD_OPEN && proto == SCS_PROTO_TCP |=> state_q == SCS_ST_TCP_INIT && o_open_req;
    endproperty
    a_open_tcp: assert property (p_open_tcp) else $error("tcp open state wrong"); // see RL4

    property p_open_raw_ip;
        cmd == SCS_CMD_OPEN && proto == SCS_PROTO_IPRAW |=> state_q == SCS_ST_RAW_IP;
    endproperty
    a_open_raw_ip: assert property (p_open_raw_ip) else $error("raw ip open state wrong"); // see RL4

    property p_open_dsl;
        cmd == SCS_CMD_OPEN && proto == SCS_PROTO_DSL |=> state_q == (IS_SOCK0 ? SCS_ST_DSL : $past(state_q));
    endproperty
    a_open_dsl: assert property (p_open_dsl) else $error("dsl open state wrong"); // see RL5

    property p_listen;
        cmd == SCS_CMD_LISTEN && is_tcp && state_q == SCS_ST_TCP_INIT
            |=> state_q == SCS_ST_WAITING && o_listen_req;
    endproperty
    a_listen: assert property (p_listen) else $error("listen did not wait"); // see RL7

    property p_listen_ok;
        in_wait && i_conn_ok |=> state_q == SCS_ST_CONNECTED && flags[SCS_FLAG_CON];
    endproperty
    a_listen_ok: assert property (p_listen_ok) else $error("listen success missed"); // see RL8

    property p_listen_fail;
        in_wait && !i_conn_ok && i_synack_fail |=> state_q == SCS_ST_SHUT && flags[SCS_FLAG_TCP_TIMEOUT_FLAG];
    endproperty
    a_listen_fail: assert property (p_listen_fail) else $error("listen failure missed"); // see RL9

    property p_no_port;
        seq_q == SEQ_WAITING && i_syn_no_port && !cmd_taken && !i_conn_ok && !i_synack_fail
            |=> o_send_rst && $stable(state_q);
    endproperty
    a_no_port: assert property (p_no_port) else $error("rst reply wrong"); // see RL10

    property p_connect_arp;
        s_connect_issue ##1 o_connect_req ##0 s_connect_arp_fail
            |=> state_q == SCS_ST_SHUT && flags[SCS_FLAG_ADDR_RESOLUTION_TIMEOUT];
    endproperty
    a_connect_arp: assert property (p_connect_arp) else $error("arp failure missed"); // see RL13, RL16

    property p_connect_tcp_timeout_flag;
        in_conn && !i_conn_ok && !i_arp_timeout && i_syn_timeout
            |=> state_q == SCS_ST_SHUT && flags[SCS_FLAG_TCP_TIMEOUT_FLAG];
    endproperty
    a_connect_tcp_timeout_flag: assert property (p_connect_tcp_timeout_flag) else $error("syn timeout missed"); // see RL14, RL16

    property p_non_tcp;
        (cmd == SCS_CMD_LISTEN || cmd == SCS_CMD_CONNECT) && !is_tcp && seq_q == SEQ_IDLE
            |=> $stable(state_q) && !o_listen_req && !o_connect_req;
    endproperty
    a_non_tcp: assert property (p_non_tcp) else $error("non tcp command acted"); // see RL17

    property p_open_dgram;
        cmd == SCS_CMD_OPEN && proto == SCS_PROTO_UDP |=> state_q == SCS_ST_DGRAM && o_open_req;
    endproperty
    a_open_dgram: assert property (p_open_dgram) else $error("udp open state wrong"); // see RL4

    property p_open_raw_mac;
        cmd == SCS_CMD_OPEN && proto == SCS_PROTO_MAC |=> state_q == (IS_SOCK0 ? SCS_ST_RAW_MAC : $past(state_q));
    endproperty
    a_open_raw_mac: assert property (p_open_raw_mac) else $error("raw mac open state wrong"); // see RL5

    property p_open_none;
        cmd == SCS_CMD_OPEN && proto == SCS_PROTO_NONE |=> $stable(state_q) && !o_open_req;
    endproperty
    a_open_none: assert property (p_open_none) else $error("closed protocol open acted"); // see RL3

    property p_connect_req;
        s_connect_issue |=> o_connect_req && state_q == SCS_ST_TCP_INIT;
    endproperty
    a_connect_req: assert property (p_connect_req) else $error("connect request missing"); // see RL11

    property p_cmd_running;
        s_connect_issue ##0 !wr_cmd |=> cmd == SCS_CMD_RESET && seq_q == SEQ_CONNECTING;
    endproperty
    a_cmd_running: assert property (p_cmd_running) else $error("connect stopped at clear"); // see RL1, RL2

    property p_connect_ok;
        in_conn && i_conn_ok |=> state_q == SCS_ST_CONNECTED && flags[SCS_FLAG_CON];
    endproperty
    a_connect_ok: assert property (p_connect_ok) else $error("connect success missed"); // see RL12

    property p_connect_rst;
        in_conn && !i_conn_ok && !i_arp_timeout && !i_syn_timeout && i_rst_received
            |=> state_q == SCS_ST_SHUT;
    endproperty
    a_connect_rst: assert property (p_connect_rst) else $error("rst reply not shut"); // see RL15, RL16

    property p_rst_outside;
        i_syn_no_port && seq_q != SEQ_WAITING |=> !o_send_rst;
    endproperty
    a_rst_outside: assert property (p_rst_outside) else $error("rst asked outside listen"); // see RL10

    property p_listen_refused;
        cmd == SCS_CMD_LISTEN && state_q != SCS_ST_TCP_INIT && seq_q == SEQ_IDLE
            |=> $stable(state_q) && !o_listen_req;
    endproperty
    a_listen_refused: assert property (p_listen_refused) else $error("listen from wrong state"); // see RL7

    property p_non_tcp_flags;
        (cmd == SCS_CMD_LISTEN || cmd == SCS_CMD_CONNECT) && !is_tcp && seq_q == SEQ_IDLE && !wr_flags
            |=> $stable(flags);
    endproperty
    a_non_tcp_flags: assert property (p_non_tcp_flags) else $error("non tcp command set flags"); // see RL17
endmodule : scs_sequencer

`default_nettype wire

/* File: scs_engine_model.sv */
/*
 * Behavioural protocol engine standing beside the socket sequencer.
 * Assumes the request pulses are on i_ref_clk. The bench picks one outcome and a delay.
 */
`default_nettype none

module scs_engine_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_listen_req,
    input  wire logic       i_connect_req,
    input  wire logic [2:0] i_outcome,
    input  wire logic [7:0] i_delay,
    output logic            o_conn_ok,
    output logic            o_synack_fail,
    output logic            o_arp_timeout,
    output logic            o_syn_timeout,
    output logic            o_rst_received,
    output logic            o_syn_no_port
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [5:0] ev_q = 6'h00;

    // Outcome 1..6 selects one event; 0 stays silent, like a peer that never answers
    assign o_conn_ok      = ev_q[0];
    assign o_synack_fail  = ev_q[1];
    assign o_arp_timeout  = ev_q[2];
    assign o_syn_timeout  = ev_q[3];
    assign o_rst_received = ev_q[4];
    assign o_syn_no_port  = ev_q[5];

    // One pulse per request; a second request during the wait is not served
    always @(posedge i_ref_clk) begin
        if (i_listen_req || i_connect_req) begin
            repeat (i_delay) @(posedge i_ref_clk);
            if (i_outcome != 3'h0) ev_q <= 6'h01 << (i_outcome - 3'h1);
            @(posedge i_ref_clk);
            ev_q <= 6'h00;
        end
    end
endmodule : scs_engine_model

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for the socket command sequencer.
 * Assumes socket zero and the engine model answering listen and connect requests.
 */
`default_nettype none

module tb
    import scs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [3:0] proto;
        logic [7:0] cmd;
        logic [2:0] outc;
        logic [7:0] st;
        logic [7:0] fl;
        logic       rst;
    } scs_row_t;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic        wr = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic        rd = 1'b0;
    logic [2:0]  outcome = 3'h0;
    logic [7:0]  delay = 8'h03;
    logic        ok, sf, arp, sto, rrx, nop;
    logic [7:0]  rdata, state;
    logic [3:0]  proto_f;
    logic        open_req, listen_req, connect_req, send_rst;
    int          n_fail = 0;
    int          compares = 0;
    int          n_rst = 0;
    int          n_open = 0;
    int          rst_base = 0;
    int          open_base = 0;
    scs_row_t    rows [16];

    initial begin
        forever #5 clk = ~clk;
    end

    scs_sequencer #(.SOCKET_ID(3'h0)) dut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr_en(wr),
        .i_reg_wdata(wdata), .i_reg_rd_en(rd), .i_conn_ok(ok), .i_synack_fail(sf),
        .i_arp_timeout(arp), .i_syn_timeout(sto), .i_rst_received(rrx), .i_syn_no_port(nop),
        .o_reg_rdata(rdata), .o_state_code(state), .o_protocol_select_field(proto_f),
        .o_open_req(open_req), .o_listen_req(listen_req), .o_connect_req(connect_req),
        .o_send_rst(send_rst)
    );

    scs_engine_model engine (
        .i_ref_clk(clk), .i_listen_req(listen_req), .i_connect_req(connect_req),
        .i_outcome(outcome), .i_delay(delay), .o_conn_ok(ok), .o_synack_fail(sf),
        .o_arp_timeout(arp), .o_syn_timeout(sto), .o_rst_received(rrx), .o_syn_no_port(nop)
    );

    // Counting pulses avoids a second driver on a per-row flag
    always @(posedge clk) begin
        if (send_rst === 1'b1) n_rst++;
        if (open_req === 1'b1) n_open++;
    end

    task automatic stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic do_reset(input int n);
        @(posedge clk);
        rst <= 1'b1;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string nm, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask : rd_chk

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    initial begin
        rows = '{
            '{4'h0, 8'h00, 3'h0, 8'h00, 8'h00, 1'b0}, '{4'h1, 8'h00, 3'h0, 8'h13, 8'h00, 1'b0},
            '{4'h2, 8'h00, 3'h0, 8'h22, 8'h00, 1'b0}, '{4'h3, 8'h00, 3'h0, 8'h32, 8'h00, 1'b0},
            '{4'h4, 8'h00, 3'h0, 8'h42, 8'h00, 1'b0}, '{4'h5, 8'h00, 3'h0, 8'h5F, 8'h00, 1'b0},
            '{4'h1, 8'h02, 3'h0, 8'h14, 8'h00, 1'b0}, '{4'h1, 8'h02, 3'h1, 8'h17, 8'h01, 1'b0},
            '{4'h1, 8'h02, 3'h2, 8'h00, 8'h08, 1'b0}, '{4'h1, 8'h02, 3'h6, 8'h14, 8'h00, 1'b1},
            '{4'h1, 8'h04, 3'h1, 8'h17, 8'h01, 1'b0}, '{4'h1, 8'h04, 3'h3, 8'h00, 8'h10, 1'b0},
            '{4'h1, 8'h04, 3'h4, 8'h00, 8'h08, 1'b0}, '{4'h1, 8'h04, 3'h5, 8'h00, 8'h00, 1'b0},
            '{4'h2, 8'h02, 3'h1, 8'h22, 8'h00, 1'b0}, '{4'h2, 8'h04, 3'h1, 8'h22, 8'h00, 1'b0}
        };
        do_reset(10);
        rd_chk("mode reset", SCS_OFS_MODE, SCS_MODE_RST);
        rd_chk("command reset", SCS_OFS_CMD, 8'h00);
        rd_chk("flags reset", SCS_OFS_FLAGS, SCS_FLAGS_RST);
        rd_chk("state reset", SCS_OFS_STATE, SCS_ST_SHUT);
        wr_reg(16'h4010, 8'hA5);
        rd_chk("unmapped", 16'h4010, 8'h00);
        wr_reg(SCS_OFS_STATE, 8'h5A);
        rd_chk("state read only", SCS_OFS_STATE, SCS_ST_SHUT);
        for (int i = 0; i < 16; i++) begin
            do_reset(2);
            outcome <= rows[i].outc;
            rst_base = n_rst;
            open_base = n_open;
            wr_reg(SCS_OFS_MODE, {4'h0, rows[i].proto});
            wr_reg(SCS_OFS_CMD, SCS_CMD_OPEN);
            if (rows[i].cmd != 8'h00) wr_reg(SCS_OFS_CMD, rows[i].cmd);
            repeat (20) @(posedge clk);
            chk("protocol field", {4'h0, rows[i].proto}, {4'h0, proto_f});
            rd_chk("command", SCS_OFS_CMD, 8'h00);
            rd_chk("state", SCS_OFS_STATE, rows[i].st);
            rd_chk("flags", SCS_OFS_FLAGS, rows[i].fl);
            chk("rst request", {7'h00, rows[i].rst}, {7'h00, n_rst != rst_base});
            chk("open request", {7'h00, rows[i].proto != 4'h0}, {7'h00, n_open != open_base});
        end
        // Slow peer: command already clear while the connect is still running
        do_reset(2);
        outcome <= 3'h1;
        delay <= 8'd30;
        wr_reg(SCS_OFS_MODE, {4'h0, SCS_PROTO_TCP});
        wr_reg(SCS_OFS_CMD, SCS_CMD_OPEN);
        wr_reg(SCS_OFS_CMD, SCS_CMD_CONNECT);
        rd_chk("command early", SCS_OFS_CMD, 8'h00);
        rd_chk("state early", SCS_OFS_STATE, SCS_ST_TCP_INIT);
        repeat (40) @(posedge clk);
        rd_chk("state late", SCS_OFS_STATE, SCS_ST_CONNECTED);
        wr_reg(SCS_OFS_FLAGS, 8'h01);
        rd_chk("flags cleared", SCS_OFS_FLAGS, 8'h00);
        do_reset(2);
        chk("state after reset", SCS_ST_SHUT, state);
        stop_test();
    end
endmodule : tb

`default_nettype wire
